// ---- pos_pkg.sv ----
package pos_pkg;

	// Register bus geometry
	localparam int unsigned ADR_W          = 8;
	localparam int unsigned DAT_W          = 32;
	localparam int unsigned SEL_W          = DAT_W / 8;

	// Fault inputs, in order a .. f
	localparam int unsigned FLT_N          = 6;
	localparam int unsigned FLT_A          = 0;
	localparam int unsigned FLT_B          = 1;
	localparam int unsigned FLT_C          = 2;
	localparam int unsigned FLT_D          = 3;
	localparam int unsigned FLT_E          = 4;
	localparam int unsigned FLT_F          = 5;

	// Pin groups and their slice of the pin vector
	localparam int unsigned GRP_N          = 4;
	localparam int unsigned GRP_CH34       = 0;
	localparam int unsigned GRP_CH67       = 1;
	localparam int unsigned GRP_CH0        = 2;
	localparam int unsigned GRP_CH9        = 3;
	localparam int unsigned PIN_N          = 20;
	localparam int unsigned CH34_LSB       = 0;
	localparam int unsigned CH34_W         = 6;
	localparam int unsigned CH67_LSB       = 6;
	localparam int unsigned CH67_W         = 6;
	localparam int unsigned CH0_LSB        = 12;
	localparam int unsigned CH0_W          = 4;
	localparam int unsigned CH9_LSB        = 16;
	localparam int unsigned CH9_W          = 4;

	// Register offsets (byte addresses)
	localparam logic [ADR_W-1:0] OFS_SEL_A = 8'h00;
	localparam logic [ADR_W-1:0] OFS_SEL_B = 8'h04;
	localparam logic [ADR_W-1:0] OFS_SEL_C = 8'h08;
	localparam logic [ADR_W-1:0] OFS_SEL_D = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_SEL_E = 8'h10;
	localparam logic [ADR_W-1:0] OFS_SEL_F = 8'h14;
	localparam logic [ADR_W-1:0] OFS_STAT  = 8'h18;

	// Target select register fields
	localparam int unsigned SEL_FW         = 4;
	localparam int unsigned F_CH0_EN       = 0;
	localparam int unsigned F_CH9_EN       = 1;
	localparam int unsigned F_PWM_EN       = 2;
	localparam int unsigned F_PWM_SEL      = 3;
	localparam logic [SEL_FW-1:0] SEL_RST  = 4'h0;

	// Writable bits and forced bits of each select register, inputs a .. f
	localparam logic [SEL_FW-1:0] SEL_WMASK [FLT_N] = '{4'h7, 4'h7, 4'he, 4'hf, 4'hf, 4'hd};
	localparam logic [SEL_FW-1:0] SEL_FORCE [FLT_N] = '{4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

	// Status register fields
	localparam int unsigned ST_FLAG_LSB    = 0;
	localparam int unsigned ST_LVL_LSB     = 8;
	localparam int unsigned ST_GRP_LSB     = 16;
	localparam logic [FLT_N-1:0] FLAG_RST  = 6'h00;

endpackage : pos_pkg

// ---- pos_flag.sv ----
`timescale 1ns/1ns
// Sticky detection flag: set by a fault, cleared by software, set wins
module pos_flag
(
	input  wire logic clk_i,   // Peripheral clock
	input  wire logic rst_i,   // Synchronous reset, active high
	input  wire logic set_i,   // Fault seen this cycle
	input  wire logic clr_i,   // Software clear strobe
	output logic      flag_o   // Latched detection
);
	import pos_pkg::*;

	logic flag_q;              // Flag state

	// Set has priority so a fault in the clear cycle is never lost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_q <= 1'b0;
		else
			flag_q <= set_i | (flag_q & ~clr_i);
	end

	assign flag_o = flag_q;

endmodule : pos_flag

// ---- pos_top.sv ----
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
// Contract
// (R1) Faults float pins regardless of port function
// (R2) Default: a-ch34, b-ch67, c-ch0, f-ch9
// (R3) Input a optionally floats ch0, ch67, ch9
// (R4) Input b optionally floats ch0, ch34, ch9
// (R5) Input c optionally floats ch34/ch67, ch9
// (R6) Inputs d,e float only selected groups
// (R7) Input f optionally floats ch34/ch67, ch0
module pos_top
#(
	parameter int unsigned PINS = pos_pkg::PIN_N   // Protected pin count
)
(
	input  wire logic                       clk_i,          // Peripheral clock, 250 MHz
	input  wire logic                       rst_i,          // Synchronous reset
	input  wire logic                       wb_cyc_i,       // Bus cycle
	input  wire logic                       wb_stb_i,       // Bus strobe
	input  wire logic                       wb_we_i,        // Write enable
	input  wire logic [pos_pkg::ADR_W-1:0]  wb_adr_i,       // Byte address
	input  wire logic [pos_pkg::SEL_W-1:0]  wb_sel_i,       // Byte lanes
	input  wire logic [pos_pkg::DAT_W-1:0]  wb_dat_i,       // Write data
	output logic      [pos_pkg::DAT_W-1:0]  wb_dat_o,       // Read data
	output logic                            wb_ack_o,       // Acknowledge
	input  wire logic                       fault_in_a_n,   // Fault input a, low = fault
	input  wire logic                       fault_in_b_n,   // Fault input b, low = fault
	input  wire logic                       fault_in_c_n,   // Fault input c, low = fault
	input  wire logic                       fault_in_d_n,   // Fault input d, low = fault
	input  wire logic                       fault_in_e_n,   // Fault input e, low = fault
	input  wire logic                       fault_in_f_n,   // Fault input f, low = fault
	input  wire logic [PINS-1:0]            port_function_select_reg_i, // 1 = timer drives
	input  wire logic [PINS-1:0]            timer_oe_i,     // Timer output enables
	input  wire logic [PINS-1:0]            gpio_oe_i,      // Port output enables
	output logic      [PINS-1:0]            pin_oe_o,       // Final pad output enables
	output logic      [pos_pkg::GRP_N-1:0]  grp_hiz_o       // Group forced to high-Z
);
	import pos_pkg::*;

	// The pin slicing below is fixed to the four timer groups
	if (PINS != PIN_N)
	begin : g_bad_pins
		$error("pos_top: PINS must equal the fixed group layout");
	end

	// Fault vector and latched flags
	logic [FLT_N-1:0]  det;                 // Active-high fault levels
	logic [FLT_N-1:0]  flag;                // Sticky detections
	logic [FLT_N-1:0]  clr;                 // Software clear strobes

	// Target select registers
	logic [SEL_FW-1:0] sel_q [FLT_N];       // Per input target choices

	// Bus handshake and read data
	logic              ack_q;               // Ack state
	logic [DAT_W-1:0]  rdat_q;              // Read data register
	logic              req;                 // New request this cycle
	logic              wr;                  // Write accepted this cycle

	// Group float and pin enables
	logic [GRP_N-1:0]  grp_d;               // Group float, next
	logic [GRP_N-1:0]  grp_q;               // Group float, registered
	logic [PINS-1:0]   hiz_pin;             // Per pin float, from groups
	logic [PINS-1:0]   oe_d;                // Pad enable, next
	logic [PINS-1:0]   oe_q;                // Pad enable, registered

	// Collect inputs; pins are taken as already synchronous
	assign det = ~{fault_in_f_n, fault_in_e_n, fault_in_d_n,
	               fault_in_c_n, fault_in_b_n, fault_in_a_n};

	// Request is new while ack is not yet out, so each access acks once
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr  = req & wb_we_i;

	// Address decode for the select registers
	function automatic logic sel_hit(input logic [ADR_W-1:0] adr, input int unsigned idx);
		logic [ADR_W-1:0] base;
		base = OFS_SEL_A + ADR_W'(idx * 4);
		return adr == base;
	endfunction : sel_hit

	// Does a flag pull in the pwm group wanted through its select register
	function automatic logic pwm_hit(input logic f, input logic [SEL_FW-1:0] s,
	                                 input logic want67);
		return f & s[F_PWM_EN] & (s[F_PWM_SEL] == want67);
	endfunction : pwm_hit

	// One sticky flag per fault input
	genvar gi;
	generate
		for (gi = 0; gi < FLT_N; gi++)
		begin : g_flag
			// Write one to a status bit clears it; set still wins
			assign clr[gi] = wr & (wb_adr_i == OFS_STAT) & wb_sel_i[0]
			                 & wb_dat_i[ST_FLAG_LSB + gi];
			pos_flag u_flag
			(
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.set_i  (det[gi]),
				.clr_i  (clr[gi]),
				.flag_o (flag[gi])
			);
		end
	endgenerate

	// Select registers; locked bits keep their fixed value
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < FLT_N; i++)
		begin
			if (rst_i)
				sel_q[i] <= SEL_RST | SEL_FORCE[i];
			else if (wr && wb_sel_i[0] && sel_hit(wb_adr_i, i))
				sel_q[i] <= (wb_dat_i[SEL_FW-1:0] & SEL_WMASK[i])
				            | (SEL_FORCE[i] & ~SEL_WMASK[i]);
		end
	end

	// Group float terms: fixed targets plus selected extras
	always_comb
	begin
		// Channel 3/4 pwm pair
		grp_d[GRP_CH34] = flag[FLT_A]                                    // see (R2)
		                | (flag[FLT_B] & sel_q[FLT_B][F_PWM_EN])         // see (R4)
		                | pwm_hit(flag[FLT_C], sel_q[FLT_C], 1'b0)       // see (R5)
		                | pwm_hit(flag[FLT_D], sel_q[FLT_D], 1'b0)       // see (R6)
		                | pwm_hit(flag[FLT_E], sel_q[FLT_E], 1'b0)       // see (R6)
		                | pwm_hit(flag[FLT_F], sel_q[FLT_F], 1'b0);      // see (R7)
		// Channel 6/7 pwm pair
		grp_d[GRP_CH67] = flag[FLT_B]                                    // see (R2)
		                | (flag[FLT_A] & sel_q[FLT_A][F_PWM_EN])         // see (R3)
		                | pwm_hit(flag[FLT_C], sel_q[FLT_C], 1'b1)       // see (R5)
		                | pwm_hit(flag[FLT_D], sel_q[FLT_D], 1'b1)       // see (R6)
		                | pwm_hit(flag[FLT_E], sel_q[FLT_E], 1'b1)       // see (R6)
		                | pwm_hit(flag[FLT_F], sel_q[FLT_F], 1'b1);      // see (R7)
		// Channel 0 pins
		grp_d[GRP_CH0]  = flag[FLT_C]                                    // see (R2)
		                | (flag[FLT_A] & sel_q[FLT_A][F_CH0_EN])         // see (R3)
		                | (flag[FLT_B] & sel_q[FLT_B][F_CH0_EN])         // see (R4)
		                | (flag[FLT_D] & sel_q[FLT_D][F_CH0_EN])         // see (R6)
		                | (flag[FLT_E] & sel_q[FLT_E][F_CH0_EN])         // see (R6)
		                | (flag[FLT_F] & sel_q[FLT_F][F_CH0_EN]);        // see (R7)
		// Channel 9 pins
		grp_d[GRP_CH9]  = flag[FLT_F]                                    // see (R2)
		                | (flag[FLT_A] & sel_q[FLT_A][F_CH9_EN])         // see (R3)
		                | (flag[FLT_B] & sel_q[FLT_B][F_CH9_EN])         // see (R4)
		                | (flag[FLT_C] & sel_q[FLT_C][F_CH9_EN])         // see (R5)
		                | (flag[FLT_D] & sel_q[FLT_D][F_CH9_EN])         // see (R6)
		                | (flag[FLT_E] & sel_q[FLT_E][F_CH9_EN]);        // see (R6)
	end

	// Spread group floats over their pins
	always_comb
	begin
		hiz_pin = '0;
		hiz_pin[CH34_LSB +: CH34_W] = {CH34_W{grp_d[GRP_CH34]}};
		hiz_pin[CH67_LSB +: CH67_W] = {CH67_W{grp_d[GRP_CH67]}};
		hiz_pin[CH0_LSB  +: CH0_W]  = {CH0_W{grp_d[GRP_CH0]}};
		hiz_pin[CH9_LSB  +: CH9_W]  = {CH9_W{grp_d[GRP_CH9]}};
	end

	// Float sits after the function mux, so no port setting can undo it
	always_comb
	begin
		for (int p = 0; p < PINS; p++)
		begin
			if (hiz_pin[p])
				oe_d[p] = 1'b0;                                          // see (R1)
			else if (port_function_select_reg_i[p])
				oe_d[p] = timer_oe_i[p];
			else
				oe_d[p] = gpio_oe_i[p];
		end
	end

	// Registered pad enables; costs one cycle of reaction time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			oe_q  <= '0;
			grp_q <= '0;
		end
		else
		begin
			oe_q  <= oe_d;
			grp_q <= grp_d;
		end
	end

	// Bus acknowledge: one cycle after the request, dropped the next
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_q <= '0;
		else if (req && !wb_we_i)
		begin
			rdat_q <= '0;
			for (int i = 0; i < FLT_N; i++)
			begin
				if (sel_hit(wb_adr_i, i))
					rdat_q <= DAT_W'(sel_q[i]);
			end
			// Status: flags, live levels and group state
			if (wb_adr_i == OFS_STAT)
				rdat_q <= (DAT_W'(flag) << ST_FLAG_LSB)
				        | (DAT_W'(det) << ST_LVL_LSB)
				        | (DAT_W'(grp_q) << ST_GRP_LSB);
		end
	end

	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = rdat_q;
	assign pin_oe_o  = oe_q;
	assign grp_hiz_o = grp_q;

endmodule : pos_top

// ---- pos_fault_src.sv ----
`timescale 1ns/1ns
// Fault sources on open-drain lines with pull-ups
module pos_fault_src
(
	input  wire logic       clk_i,    // Clock
	input  wire logic [5:0] trip_i,   // Sources to trip
	output logic      [5:0] line_n_o  // Fault lines, low = fault
);
	// Pull-up holds released lines high
	initial line_n_o = 6'h3f;
	// Sources switch just after an edge
	always @(posedge clk_i)
		line_n_o <= ~trip_i;
endmodule : pos_fault_src

// ---- pos_checker.sv ----
`timescale 1ns/1ns
// Watches the fault to float path and the bus ack
module pos_checker
#(
	parameter int unsigned PINS = 20  // Protected pin count
)
(
	input  wire logic            clk_i,                      // Clock
	input  wire logic            rst_i,                      // Reset
	input  wire logic            wb_ack_o,                   // Acknowledge
	input  wire logic            fault_in_a_n,               // Fault a
	input  wire logic            fault_in_b_n,               // Fault b
	input  wire logic            fault_in_c_n,               // Fault c
	input  wire logic            fault_in_d_n,               // Fault d
	input  wire logic            fault_in_e_n,               // Fault e
	input  wire logic            fault_in_f_n,               // Fault f
	input  wire logic [PINS-1:0] port_function_select_reg_i, // Timer or port
	input  wire logic [PINS-1:0] timer_oe_i,                 // Timer enables
	input  wire logic [PINS-1:0] gpio_oe_i,                  // Port enables
	input  wire logic [PINS-1:0] pin_oe_o,                   // Pad enables
	input  wire logic [3:0]      grp_hiz_o                   // Floating groups
);
	logic [19:0] hiz_msk;  // Pins of floating groups
	logic [19:0] sel_oe;   // Enable picked by port function
	logic        any_flt;  // Some fault line low
	assign hiz_msk = {{4{grp_hiz_o[3]}}, {4{grp_hiz_o[2]}}, {6{grp_hiz_o[1]}}, {6{grp_hiz_o[0]}}};
	assign sel_oe = (port_function_select_reg_i & timer_oe_i) | (~port_function_select_reg_i & gpio_oe_i);
	assign any_flt = ~&{fault_in_a_n, fault_in_b_n, fault_in_c_n, fault_in_d_n, fault_in_e_n, fault_in_f_n};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_fault_a_float: assert property (!fault_in_a_n |-> ##2 grp_hiz_o[0])
		else $error("fault a did not float ch34");
	a_fault_b_float: assert property (!fault_in_b_n |-> ##2 grp_hiz_o[1])
		else $error("fault b did not float ch67");
	a_fault_c_float: assert property (!fault_in_c_n |-> ##2 grp_hiz_o[2])
		else $error("fault c did not float ch0");
	a_fault_f_float: assert property (!fault_in_f_n |-> ##2 grp_hiz_o[3])
		else $error("fault f did not float ch9");
	a_float_kills_oe: assert property ((pin_oe_o & hiz_msk) == '0)
		else $error("floating pin still enabled");
	a_oe_pass_through: assert property (!$past(rst_i) && grp_hiz_o == 4'h0 |-> pin_oe_o == $past(sel_oe))
		else $error("pad enable not from port mux");
	a_float_has_cause: assert property ($rose(|grp_hiz_o) |-> $past(any_flt, 2))
		else $error("group floated without a fault");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	c_float_d: cover property (!fault_in_d_n ##2 |grp_hiz_o);
	c_two_groups: cover property (grp_hiz_o[0] && grp_hiz_o[1]);
	c_bus: cover property (wb_ack_o);
endmodule : pos_checker
bind pos_top pos_checker #(.PINS(PINS)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
	.fault_in_a_n(fault_in_a_n), .fault_in_b_n(fault_in_b_n), .fault_in_c_n(fault_in_c_n),
	.fault_in_d_n(fault_in_d_n), .fault_in_e_n(fault_in_e_n), .fault_in_f_n(fault_in_f_n),
	.port_function_select_reg_i(port_function_select_reg_i), .timer_oe_i(timer_oe_i),
	.gpio_oe_i(gpio_oe_i), .pin_oe_o(pin_oe_o), .grp_hiz_o(grp_hiz_o));

// ---- pos_top_tb_top.sv ----
`timescale 1ns/1ns
// Bus-driven tests of the fault float paths
module pos_top_tb_top;
	import pos_pkg::*;
	logic             clk_i = 1'b0;      // Clock
	logic             rst_i = 1'b1;      // Reset
	logic             cyc   = 1'b0;      // Bus cycle
	logic             stb   = 1'b0;      // Bus strobe
	logic             we    = 1'b0;      // Write
	logic [ADR_W-1:0] adr   = '0;        // Address
	logic [DAT_W-1:0] wdat  = '0;        // Write data
	logic [DAT_W-1:0] rdat;              // Read data
	logic             ack;               // Acknowledge
	logic [DAT_W-1:0] q;                 // Last read
	logic [5:0]       trip  = '0;        // Sources to trip
	logic [5:0]       flt_n;             // Fault lines
	logic [19:0]      pfs   = 20'h55555; // Mixed port functions
	logic [19:0]      goe   = 20'h0f0f0; // Port enables
	logic [19:0]      toe   = 20'hf3cf3; // Timer enables, mixed so the mux is seen
	logic [SEL_W-1:0] sel   = 4'hf;      // Byte lanes
	logic [19:0]      pin;               // Pad enables
	logic [3:0]       grp;               // Floating groups
	int               err_count = 0;     // Mismatches
	int               compares  = 0;     // Comparisons
	// Fault number, select value, expected groups
	logic [10:0] rows [14] = '{
		{3'd0, 4'h0, 4'h1}, {3'd1, 4'h0, 4'h2}, {3'd2, 4'h0, 4'h4}, {3'd5, 4'h0, 4'h8},
		{3'd3, 4'h0, 4'h0}, {3'd4, 4'h0, 4'h0},
		{3'd0, 4'h5, 4'h7}, {3'd1, 4'h6, 4'hb},
		{3'd2, 4'hc, 4'h6}, {3'd2, 4'h6, 4'hd},
		{3'd3, 4'hf, 4'he}, {3'd4, 4'h7, 4'hd},
		{3'd5, 4'h5, 4'hd}, {3'd5, 4'hc, 4'ha}};
	always #2 clk_i = ~clk_i;
	pos_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fault_in_a_n(flt_n[0]), .fault_in_b_n(flt_n[1]), .fault_in_c_n(flt_n[2]),
		.fault_in_d_n(flt_n[3]), .fault_in_e_n(flt_n[4]), .fault_in_f_n(flt_n[5]),
		.port_function_select_reg_i(pfs), .timer_oe_i(toe), .gpio_oe_i(goe),
		.pin_oe_o(pin), .grp_hiz_o(grp));
	pos_fault_src u_src (.clk_i(clk_i), .trip_i(trip), .line_n_o(flt_n));
	// One classic cycle; waits for ack, only the watchdog ends a hung wait
	task automatic acc(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
	                   input logic [SEL_W-1:0] s = 4'hf);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : acc
	task automatic chk_reg(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t reg %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	// Pads must follow the port mux except in floating groups
	task automatic chk_pins(input logic [3:0] g);
		logic [19:0] m;
		m = {{4{g[3]}}, {4{g[2]}}, {6{g[1]}}, {6{g[0]}}};
		compares++;
		if (grp !== g || pin !== (((pfs & toe) | (~pfs & goe)) & ~m))
		begin
			err_count++;
			$display("[ERR] %0t groups %h exp %h", $time, grp, g);
		end
	endtask : chk_pins
	task automatic give_verdict();
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		acc(1'b0, OFS_SEL_A, '0);
		chk_reg(q, 32'h8);
		acc(1'b0, 8'h1c, '0);
		chk_reg(q, '0);
		// Lane 0 off: the write must be ignored
		acc(1'b1, OFS_SEL_B, 32'h7, 4'he);
		acc(1'b0, OFS_SEL_B, '0);
		chk_reg(q, '0);
		for (int i = 0; i < 14; i++)
		begin
			logic [DAT_W-1:0] hit;
			hit = 32'(6'h1 << rows[i][10:8]);
			acc(1'b1, OFS_SEL_A + 8'(4 * rows[i][10:8]), 32'(rows[i][7:4]));
			trip <= 6'h1 << rows[i][10:8];
			repeat (4) @(posedge clk_i);
			chk_pins(rows[i][3:0]);
			// Clear while the line is low must not take
			acc(1'b1, OFS_STAT, 32'h3f);
			acc(1'b0, OFS_STAT, '0);
			// Flag, live level and group state all show in status
			chk_reg(q, hit | (hit << ST_LVL_LSB) | (32'(rows[i][3:0]) << ST_GRP_LSB));
			trip <= '0;
			repeat (2) @(posedge clk_i);
			acc(1'b1, OFS_STAT, 32'h3f);
			acc(1'b1, OFS_SEL_A + 8'(4 * rows[i][10:8]), '0);
			repeat (3) @(posedge clk_i);
			chk_pins(4'h0);
		end
		give_verdict();
	end
	// Hang guard, far beyond the test length
	initial
	begin
		#100000;
		err_count++;
		give_verdict();
	end
endmodule : pos_top_tb_top
